// ---- pkg/fpu_status_defs.vh ----
/*
 * Constants for the numeric status, control and exception unit:
 * register offsets, field positions, reset values and encodings.
 * Assumes inclusion by bare name from design files.
 */
`ifndef FPU_STATUS_DEFS_VH
`define FPU_STATUS_DEFS_VH

// register byte offsets on the register bus
`define OFS_CTRL        12'h000
`define OFS_STATUS      12'h004
`define OFS_INSTR_PTR   12'h008
`define OFS_OPND_PTR    12'h00C
`define OFS_OPCODE      12'h010
`define OFS_MODE        12'h014
`define OFS_CMD         12'h018

// control word fields
`define CW_MASK_LO      0
`define CW_MASK_HI      5
`define CW_PREC_LO      8
`define CW_PREC_HI      9
`define CW_RND_LO       10
`define CW_RND_HI       11
`define CW_INF_BIT      12
`define CW_RESET        16'h03FF

// status word fields
`define SW_IE           0
`define SW_DE           1
`define SW_ZE           2
`define SW_OE           3
`define SW_UE           4
`define SW_PE           5
`define SW_ES           7
`define SW_C0           8
`define SW_C1           9
`define SW_C2           10
`define SW_C3           14

// condition-code operation selects
`define CC_NONE         3'h0
`define CC_COMPARE      3'h1
`define CC_REMAINDER    3'h2
`define CC_EXAMINE      3'h3

// compare outcomes
`define CMP_GT          2'h0
`define CMP_LT          2'h1
`define CMP_EQ          2'h2
`define CMP_UN          2'h3

// examine classes (cond_d,c,b,a without sign handled separately)
`define EXM_UNNORM      3'h0
`define EXM_BADZERO     3'h1
`define EXM_NORMAL      3'h2
`define EXM_INF         3'h3
`define EXM_ZERO        3'h4
`define EXM_EMPTY       3'h5
`define EXM_BADHIGH     3'h6

// environment transfer commands
`define ENV_NONE        2'h0
`define ENV_LOAD        2'h1
`define ENV_STORE       2'h2

`define DEFAULT_NAN     80'hFFFFC000000000000000
`define POS_INF         80'h7FFF8000000000000000
`define NEG_INF         80'hFFFF8000000000000000
`define EXP_MAX         15'h7FFF

`endif

// ---- core/fpu_status_exception_control.v ----
/*
 * Status, control and exception logic of a numeric coprocessor:
 * pointer capture, condition codes, control-word decode, exception
 * detection with masked default results, sticky flags, error output.
 * Assumes an APB master on CORE_CLK and an execution unit that
 * presents one-cycle strobes with operand classes and results.
 */
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "fpu_status_defs.vh"

module fpu_status_exception_control
(
    input  wire        CORE_CLK,
    input  wire        RSTN,
    // apb slave
    input  wire        PSEL,
    input  wire        PENABLE,
    input  wire        PWRITE,
    input  wire [11:0] PADDR,
    input  wire [31:0] PWDATA,
    output reg  [31:0] PRDATA,
    output wire        PREADY,
    output wire        PSLVERR,
    // instruction start from the bus interface unit
    input  wire        INSTR_START,
    input  wire [31:0] INSTR_ADDR,
    input  wire        OPND_VALID,
    input  wire [31:0] OPND_ADDR,
    input  wire [10:0] OPCODE,
    // condition-code update from the execution unit
    input  wire        CC_STROBE,
    input  wire [2:0]  CC_OP,
    input  wire [1:0]  CMP_RESULT,
    input  wire [2:0]  QUOTIENT,
    input  wire        REDUCE_DONE,
    input  wire [1:0]  DIVIDEND_RANGE,
    input  wire [2:0]  EXAM_CLASS,
    input  wire        EXAM_SIGN,
    // exception check from the execution unit
    input  wire        EXC_STROBE,
    input  wire        STACK_FAULT,
    input  wire        INDETERMINATE,
    input  wire        IS_DIVIDE,
    input  wire [79:0] OPND_A,
    input  wire [79:0] OPND_B,
    input  wire [79:0] RAW_RESULT,
    input  wire        RESULT_TOO_BIG,
    input  wire        RESULT_TOO_SMALL,
    input  wire        RESULT_ROUNDED,
    // decoded controls and results
    output wire [1:0]  PRECISION,
    output wire [1:0]  ROUNDING,
    output wire        AFFINE,
    output reg  [79:0] RESULT,
    output reg         RESULT_VALID,
    output reg         STALL,
    output wire        ERROR
);

    reg  [15:0] ctrl_r;
    reg  [5:0]  flags_r;
    reg  [3:0]  cond_r;
    reg  [31:0] iptr_r;
    reg  [31:0] optr_r;
    reg  [10:0] opcode_r;
    reg         prot_r;
    reg  [31:0] env_buf_r;

    wire        wr_en = PSEL & PENABLE & PWRITE;
    wire        rd_en = PSEL & ~PWRITE;
    wire        hit_ctrl = (PADDR == `OFS_CTRL);
    wire        hit_stat = (PADDR == `OFS_STATUS);
    wire        hit_iptr = (PADDR == `OFS_INSTR_PTR);
    wire        hit_optr = (PADDR == `OFS_OPND_PTR);
    wire        hit_opc  = (PADDR == `OFS_OPCODE);
    wire        hit_mode = (PADDR == `OFS_MODE);
    wire        hit_cmd  = (PADDR == `OFS_CMD);
    wire        mapped   = hit_ctrl | hit_stat | hit_iptr | hit_optr |
                           hit_opc | hit_mode | hit_cmd;

    assign PREADY  = 1'b1;
    assign PSLVERR = PSEL & PENABLE & ~mapped;

    assign PRECISION = ctrl_r[`CW_PREC_HI:`CW_PREC_LO];
    assign ROUNDING  = ctrl_r[`CW_RND_HI:`CW_RND_LO];
    assign AFFINE    = ctrl_r[`CW_INF_BIT];

    wire [5:0]  masks = ctrl_r[`CW_MASK_HI:`CW_MASK_LO];

    // operand classification: 80-bit extended layout
    wire [14:0] exp_a = OPND_A[78:64];
    wire [14:0] exp_b = OPND_B[78:64];
    wire        nan_a = (exp_a == `EXP_MAX) & (OPND_A[62:0] != 63'h0);
    wire        nan_b = (exp_b == `EXP_MAX) & (OPND_B[62:0] != 63'h0);
    wire        den_a = (exp_a == 15'h0000) & (OPND_A[63:0] != 64'h0);
    wire        den_b = (exp_b == 15'h0000) & (OPND_B[63:0] != 64'h0);
    wire        zero_b = (OPND_B[78:0] == 79'h0);
    wire        zero_a = (OPND_A[78:0] == 79'h0);
    wire        inf_a  = (exp_a == `EXP_MAX) & ~nan_a;

    wire        ev_inv = STACK_FAULT | INDETERMINATE | nan_a | nan_b;
    wire        ev_den = den_a | den_b;
    wire        ev_zdv = IS_DIVIDE & zero_b & ~zero_a & ~inf_a &
                         ~nan_a;
    wire        ev_ovf = RESULT_TOO_BIG;
    wire        ev_unf = RESULT_TOO_SMALL &
                         (RAW_RESULT[63:0] != 64'h0);
    wire        ev_inx = RESULT_ROUNDED;
    wire [5:0]  events = {ev_inx, ev_unf, ev_ovf, ev_zdv, ev_den, ev_inv};
    wire [5:0]  hits   = EXC_STROBE ? events : 6'h00;

    wire        res_sign = RAW_RESULT[79];
    wire [79:0] inf_val  = res_sign ? `NEG_INF : `POS_INF;

    // masked default responses, invalid first, then zero divide, overflow, underflow; with none of these masked the raw result passes
    always @*
    begin
        RESULT = RAW_RESULT;
        if (ev_inv & masks[`SW_IE])
        begin
            if (nan_a)
                RESULT = OPND_A;
            else if (nan_b)
                RESULT = OPND_B;
            else
                RESULT = `DEFAULT_NAN;
        end
        else if (ev_zdv & masks[`SW_ZE])
            RESULT = inf_val;
        else if (ev_ovf & masks[`SW_OE])
            RESULT = inf_val;
        else if (ev_unf & masks[`SW_UE])
        begin
            // gradual underflow: exponent pinned, fraction shifted
            RESULT = {res_sign, 15'h0000, 1'b0, RAW_RESULT[63:1]};
        end
    end

    // register fields driven by software writes
    wire        clr_flags = wr_en & hit_stat;
    wire [31:0] cmd_w     = (wr_en & hit_cmd) ? PWDATA : 32'h0;

    // sticky exception flags; set wins over a same-cycle clear
    always @(posedge CORE_CLK or negedge RSTN)
    begin
        if (!RSTN)
            flags_r <= 6'h00;
        else if (clr_flags)
            flags_r <= (flags_r & ~PWDATA[5:0]) | hits;
        else
            flags_r <= flags_r | hits;
    end

    wire        es = |(flags_r & ~masks);
    assign ERROR = es;

    always @(posedge CORE_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            RESULT_VALID <= 1'b0;
            STALL        <= 1'b0;
        end
        else
        begin
            RESULT_VALID <= EXC_STROBE;
            // unmasked exception holds the next instruction
            STALL        <= |(hits & ~masks);
        end
    end

    // condition codes, bit order {cond_d, cond_c, cond_b, cond_a}
    reg [3:0] cond_nxt;
    always @*
    begin
        cond_nxt = cond_r;
        if (CC_STROBE)
        begin
            case (CC_OP)
                `CC_COMPARE:
                begin
                    case (CMP_RESULT)
                        `CMP_GT: cond_nxt = {1'b0, 1'b0, cond_r[1], 1'b0};
                        `CMP_LT: cond_nxt = {1'b0, 1'b0, cond_r[1], 1'b1};
                        `CMP_EQ: cond_nxt = {1'b1, 1'b0, cond_r[1], 1'b0};
                        default: cond_nxt = {1'b1, 1'b1, cond_r[1], 1'b1};
                    endcase
                end
                `CC_REMAINDER:
                begin
                    if (!REDUCE_DONE)
                        cond_nxt = {cond_r[3], 1'b1, cond_r[1:0]};
                    else
                    begin
                        // d=Q1, c=0, b=Q0, a=Q2
                        cond_nxt = {QUOTIENT[1], 1'b0, QUOTIENT[0],
                                    QUOTIENT[2]};
                        if (DIVIDEND_RANGE == 2'h0)
                            cond_nxt = {cond_r[3], 1'b0, cond_r[1],
                                        QUOTIENT[0]};
                        else if (DIVIDEND_RANGE == 2'h1)
                            cond_nxt = {cond_r[3], 1'b0, QUOTIENT[0],
                                        QUOTIENT[2]};
                    end
                end
                `CC_EXAMINE:
                begin
                    case (EXAM_CLASS)
                        `EXM_UNNORM:  cond_nxt = {3'h0, 1'b0};
                        `EXM_BADZERO: cond_nxt = {3'h0, 1'b1};
                        `EXM_NORMAL:  cond_nxt = {3'h2, 1'b0};
                        `EXM_INF:     cond_nxt = {3'h2, 1'b1};
                        `EXM_ZERO:    cond_nxt = {3'h4, 1'b0};
                        `EXM_BADHIGH: cond_nxt = {3'h6, 1'b0};
                        default:      cond_nxt = {3'h4, 1'b1};
                    endcase
                    if (EXAM_CLASS != `EXM_EMPTY && EXAM_CLASS <= `EXM_BADHIGH)
                        cond_nxt[1] = EXAM_SIGN;
                end
                default: cond_nxt = cond_r;
            endcase
        end
    end

    always @(posedge CORE_CLK or negedge RSTN)
    begin
        if (!RSTN)
            cond_r <= 4'h0;
        else
            cond_r <= cond_nxt;
    end

    // pointer capture; INSTR_ADDR must be the first prefix byte
    wire [31:0] iaddr_fmt = prot_r ? INSTR_ADDR
                                   : {12'h000, INSTR_ADDR[19:0]};
    wire [31:0] oaddr_fmt = prot_r ? OPND_ADDR
                                   : {12'h000, OPND_ADDR[19:0]};
    always @(posedge CORE_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            iptr_r    <= 32'h0;
            optr_r    <= 32'h0;
            opcode_r  <= 11'h000;
            prot_r    <= 1'b0;
            ctrl_r    <= `CW_RESET;
            env_buf_r <= 32'h0;
        end
        else
        begin
            if (INSTR_START)
            begin
                iptr_r   <= iaddr_fmt;
                if (OPND_VALID)
                    optr_r <= oaddr_fmt;
                // opcode only kept in real mode
                opcode_r <= prot_r ? 11'h000 : OPCODE;
            end
            if (wr_en & hit_ctrl)
                ctrl_r <= PWDATA[15:0];
            if (wr_en & hit_mode)
                prot_r <= PWDATA[0];
            // environment load: software writes pointers back
            if (wr_en & hit_iptr)
                iptr_r <= prot_r ? PWDATA : {12'h000, PWDATA[19:0]};
            if (wr_en & hit_optr)
                optr_r <= prot_r ? PWDATA : {12'h000, PWDATA[19:0]};
            if (wr_en & hit_opc)
                opcode_r <= PWDATA[10:0];
            // store command snapshots the instruction pointer
            if (cmd_w[1:0] == `ENV_STORE)
                env_buf_r <= iptr_r;
        end
    end

    wire [15:0] status_w = {1'b0, cond_r[3], 3'h0, cond_r[2], cond_r[1],
                            cond_r[0], es, 1'b0, flags_r};

    always @*
    begin
        PRDATA = 32'h0;
        if (rd_en)
        begin
            if (hit_ctrl)
                PRDATA = {16'h0000, ctrl_r};
            else if (hit_stat)
                PRDATA = {16'h0000, status_w};
            else if (hit_iptr)
                PRDATA = iptr_r;
            else if (hit_optr)
                PRDATA = optr_r;
            else if (hit_opc)
                PRDATA = {21'h000000, opcode_r};
            else if (hit_mode)
                PRDATA = {31'h0, prot_r};
            else if (hit_cmd)
                PRDATA = env_buf_r;
        end
    end

endmodule // fpu_status_exception_control

`default_nettype wire

// ---- bench/fpu_status_exception_control_properties.sv ----
/* port checker for the status and exception unit.
   assumes it is bound onto the design top, ports joined by name. */
`timescale 1ns/1ps
`default_nettype none
`include "fpu_status_defs.vh"
module fpu_exc_props
(
    input wire logic        CORE_CLK,
    input wire logic        RSTN,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic        EXC_STROBE,
    input wire logic        STACK_FAULT,
    input wire logic [79:0] OPND_A,
    input wire logic [79:0] OPND_B,
    input wire logic [79:0] RESULT,
    input wire logic        RESULT_VALID,
    input wire logic        STALL,
    input wire logic        ERROR,
    input wire logic [1:0]  PRECISION,
    input wire logic [1:0]  ROUNDING,
    input wire logic        AFFINE
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RSTN);
    logic [15:0] ctl_r;
    wire         ctl_w = PSEL && PENABLE && PWRITE && PADDR == `OFS_CTRL;
    wire         st_w = PSEL && PENABLE && PWRITE && PADDR == `OFS_STATUS;
    // shadow of the control word, so masks can be judged from the bus
    always @(posedge CORE_CLK or negedge RSTN)
        if (!RSTN)
            ctl_r <= `CW_RESET;
        else if (ctl_w)
            ctl_r <= PWDATA[15:0];
    sequence inv_open;
        EXC_STROBE && STACK_FAULT && !ctl_r[0];
    endsequence
    sequence inv_shut;
        EXC_STROBE && STACK_FAULT && ctl_r[0]
            && OPND_A[78:64] != `EXP_MAX && OPND_B[78:64] != `EXP_MAX;
    endsequence
    ctl_decode_a: assert property (
        {AFFINE, ROUNDING, PRECISION} == ctl_r[12:8])
        else $error("control outputs differ from control word");
    inv_unmask_a: assert property (
        inv_open |=> ERROR && STALL)
        else $error("unmasked invalid gave no error");
    inv_masked_a: assert property (
        inv_shut |-> RESULT == `DEFAULT_NAN)
        else $error("masked invalid result wrong");
    result_strobe_a: assert property (
        RESULT_VALID == $past(EXC_STROBE))
        else $error("result valid not one cycle after strobe");
    err_rise_a: assert property (
        $rose(ERROR) |-> $past(EXC_STROBE) || $past(ctl_w))
        else $error("error rose without a cause");
    err_sticky_a: assert property (
        $fell(ERROR) |-> $past(st_w) || $past(ctl_w))
        else $error("error fell without software action");
    stall_cause_a: assert property (
        STALL |-> $past(EXC_STROBE) && ERROR)
        else $error("stall without unmasked exception");
    masked_quiet_a: assert property (
        EXC_STROBE && (&ctl_r[5:0]) && !ERROR && !ctl_w |=> !ERROR)
        else $error("error raised while all masked");
endmodule // fpu_exc_props
bind fpu_status_exception_control fpu_exc_props chk (
    .CORE_CLK(CORE_CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .EXC_STROBE(EXC_STROBE), .STACK_FAULT(STACK_FAULT), .OPND_A(OPND_A),
    .OPND_B(OPND_B), .RESULT(RESULT), .RESULT_VALID(RESULT_VALID),
    .STALL(STALL), .ERROR(ERROR), .PRECISION(PRECISION),
    .ROUNDING(ROUNDING), .AFFINE(AFFINE));
`default_nettype wire

// ---- bench/host_cpu_model.sv ----
/* host side model: issues coprocessor instructions to the unit.
   assumes the bench calls issue from its clocked main sequence. */
`timescale 1ns/1ps
`default_nettype none
module host_cpu_model
(
    input  wire logic        clk,
    output var  logic        start,
    output var  logic [31:0] iaddr,
    output var  logic        ov,
    output var  logic [31:0] oaddr,
    output var  logic [10:0] opc
);
    initial
    begin
        start = 1'b0;
        {iaddr, ov, oaddr, opc} = 76'h0;
    end
    task issue(input logic [31:0] a, input logic v, input logic [31:0] o,
               input logic [10:0] c);
        @(posedge clk);
        start <= 1'b1;
        {iaddr, ov, oaddr, opc} <= {a, v, o, c};
        @(posedge clk);
        start <= 1'b0;
        // lines no longer held: inverse, so a stale capture shows
        {iaddr, ov, oaddr, opc} <= ~{a, v, o, c};
    endtask
endmodule // host_cpu_model
`default_nettype wire

// ---- bench/fpu_status_exception_control_tb.sv ----
/* bench top: drives the unit over its register bus and strobes and
   compares against a reference model. assumes host model and checker. */
`timescale 1ns/1ps
`default_nettype none
`include "fpu_status_defs.vh"
module fpu_status_exception_control_tb;
    localparam logic [79:0] one_v = 80'h3FFF8000000000000000;
    localparam logic [79:0] den_v = 80'h00004000000000000000;
    localparam logic [79:0] nan_v = 80'h7FFFC000000000000001;
    logic        clk = 1'b0, rstn = 1'b0, psel = 1'b0, pen = 1'b0;
    logic        pwr = 1'b0, ccs = 1'b0, rdone = 1'b0, xsg = 1'b0;
    logic        xs = 1'b0, sf = 1'b0, ind = 1'b0, dv = 1'b0, big = 1'b0;
    logic        sml = 1'b0, rnd = 1'b0, start, ov, pready, slv, se;
    logic        aff, rv, stall, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, seed = 32'd53, prdata, rd, iaddr, oaddr;
    logic [10:0] opc;
    logic [2:0]  ccop = 3'h0, quo = 3'h0, xcl = 3'h0;
    logic [1:0]  cmp = 2'h0, rng = 2'h0, prec, rmode;
    logic [79:0] opa = 80'h0, opb = 80'h0, raw = 80'h0, res;
    logic [3:0]  cnd = 4'h0;
    logic [3:0]  xb [7] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9, 4'hC};
    logic [5:0]  fl = 6'h0;
    int          miscompares = 0, n_tests = 0, cyc = 0;
    fpu_status_exception_control uut (.CORE_CLK(clk), .RSTN(rstn),
        .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(slv),
        .INSTR_START(start), .INSTR_ADDR(iaddr), .OPND_VALID(ov),
        .OPND_ADDR(oaddr), .OPCODE(opc), .CC_STROBE(ccs), .CC_OP(ccop),
        .CMP_RESULT(cmp), .QUOTIENT(quo), .REDUCE_DONE(rdone),
        .DIVIDEND_RANGE(rng), .EXAM_CLASS(xcl), .EXAM_SIGN(xsg),
        .EXC_STROBE(xs), .STACK_FAULT(sf), .INDETERMINATE(ind),
        .IS_DIVIDE(dv), .OPND_A(opa), .OPND_B(opb), .RAW_RESULT(raw),
        .RESULT_TOO_BIG(big), .RESULT_TOO_SMALL(sml),
        .RESULT_ROUNDED(rnd), .PRECISION(prec), .ROUNDING(rmode),
        .AFFINE(aff), .RESULT(res), .RESULT_VALID(rv), .STALL(stall),
        .ERROR(err));
    host_cpu_model cpu (.clk(clk), .start(start), .iaddr(iaddr), .ov(ov),
        .oaddr(oaddr), .opc(opc));
    always #2.5 clk = ~clk;
    function logic [31:0] xr();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function logic [31:0] st(input logic [5:0] mk);
        return {17'h0, cnd[3], 3'h0, cnd[2:0], |(fl & ~mk), 1'b0, fl};
    endfunction
    task chk(input string nm, input logic [79:0] seen, input logic [79:0] ex);
        n_tests++;
        if (seen !== ex)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, ex, seen);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int t;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        t = 0;
        do
            @(posedge clk);
        while (pready !== 1'b1 && ++t < 50);
        rd = prdata;
        se = slv;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task rdchk(input logic [11:0] a, input logic [31:0] ex);
        apb(1'b0, a, 32'h0);
        chk("read data", rd, ex);
    endtask
    task strobe(input logic e);
        @(posedge clk);
        xs <= e;
        ccs <= !e;
        @(negedge clk);
    endtask
    task lower();
        @(posedge clk);
        xs <= 1'b0;
        ccs <= 1'b0;
        @(negedge clk);
    endtask
    task close_out();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            miscompares++;
            close_out();
        end
    end
    initial
    begin
        logic [31:0] a, o, v;
        logic [10:0] c;
        logic [2:0]  q;
        logic [5:0]  mk;
        logic [79:0] r80, ex;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rdchk(`OFS_CTRL, 32'h03FF);
        rdchk(`OFS_STATUS, 32'h0);
        apb(1'b0, 12'h01C, 32'h0);
        chk("unmapped", {rd, se}, 33'h1);
        v = xr();
        apb(1'b1, `OFS_CTRL, v);
        @(negedge clk);
        chk("ctrl decode", {aff, rmode, prec}, v[12:8]);
        apb(1'b1, `OFS_CTRL, 32'h03FF);
        $display("test control done");
        for (int p = 0; p < 2; p++)
        begin
            apb(1'b1, `OFS_MODE, p);
            a = xr();
            o = xr();
            c = 11'(xr());
            cpu.issue(a, 1'b1, o, c);
            rdchk(`OFS_INSTR_PTR, p ? a : a & 32'hFFFFF);
            rdchk(`OFS_OPCODE, p ? 32'h0 : {21'h0, c});
            cpu.issue(xr(), 1'b0, xr(), c);
            rdchk(`OFS_OPND_PTR, p ? o : o & 32'hFFFFF);
        end
        apb(1'b1, `OFS_INSTR_PTR, v);
        apb(1'b1, `OFS_CMD, 32'h2);
        rdchk(`OFS_CMD, v);
        $display("test pointers done");
        for (int i = 0; i < 4; i++)
        begin
            ccop <= `CC_COMPARE;
            cmp <= 2'(i);
            strobe(1'b0);
            lower();
            cnd = {i >= 2, i == 3, cnd[1], i[0]};
            rdchk(`OFS_STATUS, st(6'h3F));
        end
        for (int r = 0; r < 4; r++)
        begin
            q = 3'(xr());
            ccop <= `CC_REMAINDER;
            quo <= q;
            rng <= 2'(r);
            rdone <= r < 3;
            strobe(1'b0);
            lower();
            cnd = {r >= 2 ? q[1] : cnd[3], 1'b0, r ? q[0] : cnd[1], r ? q[2] : q[0]};
            apb(1'b0, `OFS_STATUS, 32'h0);
            if (r < 3)
                chk("status", rd, st(6'h3F));
            else
                chk("cond_c", rd[10], 1'b1);
        end
        for (int k = 0; k < 14; k++)
        begin
            ccop <= `CC_EXAMINE;
            xcl <= 3'(k >> 1);
            xsg <= k[0];
            strobe(1'b0);
            lower();
            cnd = xb[k >> 1] | {2'b0, k[0] && (k >> 1) != 5, 1'b0};
            rdchk(`OFS_STATUS, st(6'h3F));
        end
        $display("test condition codes done");
        for (int m = 0; m < 2; m++)
        begin
            mk = m ? 6'h00 : 6'h3F;
            apb(1'b1, `OFS_CTRL, 32'h03C0 | mk);
            for (int k = 0; k < 7; k++)
            begin
                r80 = {16'h3FFF, xr(), xr()};
                sf <= k == 0;
                opa <= k == 1 ? den_v : k == 6 ? nan_v : one_v;
                dv <= k == 2;
                opb <= k == 2 ? 80'h0 : one_v;
                big <= k == 3;
                sml <= k == 4;
                rnd <= k == 5;
                ind <= k == 6;
                raw <= r80;
                strobe(1'b1);
                ex = m ? r80 : k == 0 ? `DEFAULT_NAN : k == 6 ? nan_v : r80;
                if (!m && (k == 2 || k == 3))
                    ex = `POS_INF;
                if (!m && k == 4)
                    ex = {16'h0, 1'b0, r80[63:1]};
                chk("result", res, ex);
                lower();
                fl[k % 6] = 1'b1;
                chk("valid stall error", {rv, stall, err}, {1'b1, m[0], m[0]});
                rdchk(`OFS_STATUS, st(mk));
                if (m)
                begin
                    apb(1'b1, `OFS_STATUS, 32'h3F);
                    fl = 6'h0;
                    @(negedge clk);
                    chk("error cleared", err, 1'b0);
                end
            end
            apb(1'b1, `OFS_STATUS, 32'h3F);
            fl = 6'h0;
        end
        $display("test exceptions done");
        close_out();
    end
endmodule // fpu_status_exception_control_tb
`default_nettype wire
